// ==== hdl/pog_pin_sync.sv ====
// two-stage synchroniser for the port pins
// assumes the pins are asynchronous to hclk
`timescale 1ns/100ps
module pog_pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

// ==== hdl/pog_port_one.sv ====
// port one gpio with low address byte output, ahb-lite register slave
// assumes one ahb-lite master, mode pins static, hw_standby_n a synchronous level
//
// Overview of operation
// R1 - In expanded mode a pin drives its address line when its direction bit is 1, else it is an input.
// R2 - In single-chip modes each pin is an output when its direction bit is 1, else an input.
// R3 - The direction register is write-only and reads back as all ones.
// R4 - The direction register clears on reset and hardware standby and holds in software standby unless written.
// R5 - In software standby a pin whose direction bit is 1 keeps driving its present output.
// R6 - A port read returns the latch bit for any pin whose direction bit is 1.
// R7 - A port read returns the sampled pin level for any pin whose direction bit is 0.
// R8 - The output latch clears on reset and hardware standby and holds in software standby unless written.
// R9 - After reset in expanded mode software must set direction bits before address lines appear.
// R10 - Direction decodes at FFC0 and the latch at FFC2 on the low sixteen address bits.
// R11 - Latch writes outside hardware standby are stored and drive the pin in single-chip modes once its direction bit is 1.
`timescale 1ns/100ps
module pog_port_one #(
  parameter int unsigned PIN_W = pog_pkg::PIN_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [1:0] op_mode,
  input wire logic hw_standby_n,
  input wire logic sw_standby,
  input wire logic [PIN_W-1:0] addr_low,
  input wire logic [PIN_W-1:0] pin_in,
  output logic [PIN_W-1:0] pin_out,
  output logic [PIN_W-1:0] pin_oe_n
);
  logic [PIN_W-1:0] dir_q;
  logic [PIN_W-1:0] latch_q;
  logic [PIN_W-1:0] pin_sync;
  logic [PIN_W-1:0] out_q;
  logic [PIN_W-1:0] oe_n_q;
  logic wr_pend_q;
  logic [15:0] dp_addr_q;
  logic [31:0] hrdata_q;
  logic [PIN_W-1:0] out_d;
  logic [PIN_W-1:0] oe_n_d;

  pog_pin_sync #(.WIDTH(PIN_W)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_i(pin_in),
    .sync_o(pin_sync)
  );

  // one compare serves both the address phase and the pending write
  function automatic logic reg_match(input logic [15:0] a, input logic [15:0] offs);
    return (a == offs);
  endfunction

  // address phase qualification; only the low 16 address bits take part
  wire addr_phase = hsel && hready && htrans[1];
  wire hit_dir = reg_match(haddr[15:0], pog_pkg::DIR_OFFSET); // R10
  wire hit_latch = reg_match(haddr[15:0], pog_pkg::LATCH_OFFSET); // R10
  wire rd_take = addr_phase && !hwrite;
  wire wr_take = addr_phase && hwrite;
  wire wr_dir = wr_pend_q && reg_match(dp_addr_q, pog_pkg::DIR_OFFSET); // R10
  wire wr_latch = wr_pend_q && reg_match(dp_addr_q, pog_pkg::LATCH_OFFSET); // R10
  wire expanded = (op_mode == pog_pkg::MODE_EXPANDED);
  wire stby_hold = sw_standby && !wr_pend_q;

  // read value: latch where driven, pin level where input
  wire [PIN_W-1:0] port_rd = (dir_q & latch_q) | (~dir_q & pin_sync); // R6 R7
  wire [31:0] rd_value = hit_dir ? {24'h000000, pog_pkg::DIR_READBACK} : // R3
                         hit_latch ? {24'h000000, port_rd} : 32'h00000000;

  // write data is taken in the data phase, one cycle after the address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      dp_addr_q <= 16'h0000;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= wr_take;
      if (addr_phase) begin
        dp_addr_q <= haddr[15:0];
      end
      if (rd_take) begin
        hrdata_q <= rd_value;
      end
    end
  end

  // hardware standby clears both registers; software standby has no effect on them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_q <= pog_pkg::DIR_RESET; // R4
      latch_q <= pog_pkg::LATCH_RESET; // R8
    end else if (!hw_standby_n) begin
      dir_q <= pog_pkg::DIR_RESET; // R4
      latch_q <= pog_pkg::LATCH_RESET; // R8
    end else begin
      if (wr_dir) begin
        dir_q <= hwdata[PIN_W-1:0];
      end
      if (wr_latch) begin
        latch_q <= hwdata[PIN_W-1:0]; // R11
      end
    end
  end

  // pin driver: address byte in expanded mode, latch otherwise
  always_comb begin
    out_d = expanded ? addr_low : latch_q; // R1 R2 R11
    oe_n_d = ~dir_q; // R1 R2
    if (sw_standby) begin
      out_d = out_q; // R5
      oe_n_d = oe_n_q; // R5
    end
  end

  // registered pins; software standby freezes the driven state rather than floating it, hardware standby releases the pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_q <= {PIN_W{1'b0}};
      oe_n_q <= {PIN_W{1'b1}};
    end else if (!hw_standby_n) begin
      out_q <= {PIN_W{1'b0}};
      oe_n_q <= {PIN_W{1'b1}};
    end else begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign pin_out = out_q;
  assign pin_oe_n = oe_n_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // direction register readback never reveals the stored value
  dir_reads_ones_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    (rd_take && hit_dir) |=> (hrdata[7:0] == 8'hFF))
    else $error("direction read did not return all ones");

  dir_hw_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    !hw_standby_n |=> (dir_q == 8'h00))
    else $error("direction not cleared by hardware standby");

  latch_hw_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    !hw_standby_n |=> (latch_q == 8'h00))
    else $error("latch not cleared by hardware standby");

  dir_sw_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    (sw_standby && hw_standby_n && !wr_pend_q) |=> $stable(dir_q))
    else $error("direction changed in software standby");

  latch_sw_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    (stby_hold && hw_standby_n) |=> $stable(latch_q))
    else $error("latch changed in software standby");

  pins_frozen_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    (sw_standby && hw_standby_n) |=> ($stable(pin_out) && $stable(pin_oe_n)))
    else $error("pins moved in software standby");

  latch_store_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    (wr_latch && hw_standby_n) |=> (latch_q == $past(hwdata[7:0])))
    else $error("latch write not stored");

  dir_store_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    (wr_take && hit_dir) ##1 hw_standby_n |=> (dir_q == $past(hwdata[7:0])))
    else $error("direction write at its offset not stored");

  pin_drive_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    (!sw_standby && hw_standby_n && !expanded) |=>
      (pin_oe_n == ~$past(dir_q) && pin_out == $past(latch_q)))
    else $error("single-chip pin drive mismatch");

  addr_drive_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    (!sw_standby && hw_standby_n && expanded) |=> (pin_out == $past(addr_low)))
    else $error("expanded mode address not driven");

  port_read_a: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    (rd_take && hit_latch) |=> (hrdata[7:0] == $past(port_rd)))
    else $error("port read value mismatch");

  // check helpers: pin snapshot taken at standby entry
  logic in_stby_q;
  logic [PIN_W-1:0] snap_out_q;
  logic [PIN_W-1:0] snap_oe_n_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_stby_q <= 1'b0;
      snap_out_q <= {PIN_W{1'b0}};
      snap_oe_n_q <= {PIN_W{1'b1}};
    end else begin
      in_stby_q <= sw_standby && hw_standby_n;
      if (!in_stby_q) begin
        snap_out_q <= out_q;
        snap_oe_n_q <= oe_n_q;
      end
    end
  end

  // independent write model; decodes the address phase afresh so a decode slip shows up
  logic shadow_wdir_q;
  logic shadow_wlat_q;
  logic [PIN_W-1:0] shadow_dir_q;
  logic [PIN_W-1:0] shadow_latch_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shadow_wdir_q <= 1'b0;
      shadow_wlat_q <= 1'b0;
      shadow_dir_q <= pog_pkg::DIR_RESET;
      shadow_latch_q <= pog_pkg::LATCH_RESET;
    end else begin
      shadow_wdir_q <= hsel && hready && htrans[1] && hwrite &&
                       (haddr[15:0] == pog_pkg::DIR_OFFSET);
      shadow_wlat_q <= hsel && hready && htrans[1] && hwrite &&
                       (haddr[15:0] == pog_pkg::LATCH_OFFSET);
      if (!hw_standby_n) begin
        shadow_dir_q <= pog_pkg::DIR_RESET;
        shadow_latch_q <= pog_pkg::LATCH_RESET;
      end else begin
        if (shadow_wdir_q) begin
          shadow_dir_q <= hwdata[PIN_W-1:0];
        end
        if (shadow_wlat_q) begin
          shadow_latch_q <= hwdata[PIN_W-1:0];
        end
      end
    end
  end

  oe_follows_dir_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    (!sw_standby && hw_standby_n) |=>
      (pin_oe_n == ~$past(dir_q)))
    else $error("output enable does not follow direction");

  no_dir_no_drive_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    (!sw_standby && hw_standby_n && (dir_q == 8'h00)) |=>
      (pin_oe_n == 8'hFF))
    else $error("pin driven with direction clear");

  rd_unmapped_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    (rd_take && !hit_dir && !hit_latch) |=> (hrdata == 32'h00000000))
    else $error("unmapped read not zero");

  rd_upper_zero_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    rd_take |=> (hrdata[31:8] == 24'h000000))
    else $error("read upper bits not zero");

  rd_dir_word_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    (rd_take && hit_dir) |=> (hrdata == 32'h000000FF))
    else $error("direction read word wrong");

  hrdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    !rd_take |=> $stable(hrdata))
    else $error("read data moved without a read");

  dir_write_only_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    (!wr_dir && hw_standby_n) |=> $stable(dir_q))
    else $error("direction changed without its write");

  latch_write_only_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    (!wr_latch && hw_standby_n) |=> $stable(latch_q))
    else $error("latch changed without its write");

  read_input_bits_a: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    (rd_take && hit_latch) |=>
      ((hrdata[7:0] & ~$past(dir_q)) == ($past(pin_sync) & ~$past(dir_q))))
    else $error("input pins not read from pin level");

  read_latch_bits_a: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    (rd_take && hit_latch) |=>
      ((hrdata[7:0] & $past(dir_q)) == ($past(latch_q) & $past(dir_q))))
    else $error("output pins not read from latch");

  hw_pins_release_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    !hw_standby_n |=>
      ((pin_oe_n == 8'hFF) && (pin_out == 8'h00)))
    else $error("pins not released in hardware standby");

  write_pend_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    wr_take |=> wr_pend_q)
    else $error("write address phase not held for data");

  no_stray_pend_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    !wr_take |=> !wr_pend_q)
    else $error("data phase write without address phase");

  idle_no_write_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    (!hsel || !htrans[1]) |=> !wr_pend_q)
    else $error("idle bus produced a write");

  // a pin level reaches the read path exactly two edges late
  pin_sync_delay_a: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    ($past(hresetn) && $past(hresetn, 2)) |->
      (pin_sync == $past(pin_in, 2)))
    else $error("pin synchroniser delay wrong");

  data_addr_keep_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    addr_phase |=> (dp_addr_q == $past(haddr[15:0])))
    else $error("data phase address not kept");

  pend_addr_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    wr_pend_q |-> (dp_addr_q == $past(haddr[15:0])))
    else $error("pending write lost its address");

  dir_read_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    (rd_take && !wr_dir && hw_standby_n) |=> $stable(dir_q))
    else $error("direction read disturbed the register");

  latch_read_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    (rd_take && !wr_latch && hw_standby_n) |=> $stable(latch_q))
    else $error("port read disturbed the latch");

  dir_write_lands_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    (wr_dir && hw_standby_n) |=> (dir_q == $past(hwdata[7:0])))
    else $error("direction write not stored");

  // the cpu is normally halted in software standby, but a write still lands
  stby_latch_store_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    (wr_latch && sw_standby && hw_standby_n) |=> (latch_q == $past(hwdata[7:0])))
    else $error("latch write in software standby lost");

  stby_out_snap_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    in_stby_q |-> (pin_out == snap_out_q))
    else $error("pin value left its standby snapshot");

  stby_oe_snap_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    in_stby_q |-> (pin_oe_n == snap_oe_n_q))
    else $error("pin enable left its standby snapshot");

  dir_model_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    (dir_q == shadow_dir_q))
    else $error("direction differs from write model");

  latch_model_a: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    (latch_q == shadow_latch_q))
    else $error("latch differs from write model");
endmodule

// ==== inc/pog_pkg.sv ====
// constants for the port one gpio block: register offsets, reset values, modes
// assumes a 32-bit ahb-lite register bus with byte addresses on the low 16 bits
package pog_pkg;
  localparam int unsigned ADDR_MATCH_W = 16;
  localparam logic [15:0] DIR_OFFSET = 16'hFFC0;
  localparam logic [15:0] LATCH_OFFSET = 16'hFFC2;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] DIR_READBACK = 8'hFF;
  localparam logic [1:0] MODE_EXPANDED = 2'h1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int unsigned PIN_W = 8;
endpackage

// ==== verification/pog_pin_load.sv ====
// pin-side load model for port one: pull level where the port is not driving
// assumes pin_oe_n low means the port drives that pin
`timescale 1ns/100ps
module pog_pin_load (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_in
);
  // the load's own level wins on released pins, so a stale output never reads back
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the port one block over ahb-lite
// assumes one slave, so hready is fed back from hreadyout
`timescale 1ns/100ps
module testbench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hw_standby_n = 1, sw_standby = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0] htrans = 0, op_mode = 2'h2;
  logic [7:0] addr_low = 8'h5A, ext = 8'hA5, pin_in, pin_out, pin_oe_n;
  logic hreadyout, hresp;
  int num_errors = 0, n_checks = 0, cyc = 0;
  always #10 hclk = ~hclk;
  pog_port_one dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(pog_pkg::HSIZE_WORD), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .op_mode(op_mode), .hw_standby_n(hw_standby_n), .sw_standby(sw_standby),
    .addr_low(addr_low), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  pog_pin_load load (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext),
    .pin_in(pin_in));
  task complete_run;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      complete_run;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1;
    haddr <= {16'h00FF, a};
    htrans <= pog_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task settle;
    repeat (3) @(posedge hclk);
    #1;
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    settle;
    chk(pin_oe_n, 8'hFF);
    chk(pin_out, 8'h00);
    xfer(0, pog_pkg::DIR_OFFSET, 8'h00); chk(r, 32'h000000FF);
    chk({31'h00000000, hresp}, 32'h00000000);
    chk({31'h00000000, hreadyout}, 32'h00000001);
    xfer(0, pog_pkg::LATCH_OFFSET, 8'h00); chk(r, 32'h000000A5);
    xfer(1, pog_pkg::LATCH_OFFSET, 8'h3C); settle; chk(pin_oe_n, 8'hFF);
    xfer(1, pog_pkg::DIR_OFFSET, 8'h0F); settle; chk(pin_oe_n, 8'hF0);
    chk(pin_out[3:0], 4'hC);
    xfer(0, pog_pkg::LATCH_OFFSET, 8'h00); chk(r, 32'h000000AC);
    xfer(0, pog_pkg::DIR_OFFSET, 8'h00); chk(r, 32'h000000FF);
    xfer(0, 16'hFFC4, 8'h00); chk(r, 32'h00000000);
    xfer(1, 16'hFFC1, 8'hFF); settle; chk(pin_oe_n, 8'hF0);
    @(posedge hclk) sw_standby <= 1;
    xfer(1, pog_pkg::LATCH_OFFSET, 8'h03); settle; chk(pin_out[3:0], 4'hC);
    @(posedge hclk) sw_standby <= 0;
    settle; chk(pin_out[3:0], 4'h3);
    @(posedge hclk) op_mode <= pog_pkg::MODE_EXPANDED;
    settle; chk(pin_out[3:0], 4'hA);
    chk(pin_oe_n, 8'hF0);
    @(posedge hclk) hw_standby_n <= 0;
    settle;
    @(posedge hclk) hw_standby_n <= 1;
    settle; chk(pin_oe_n, 8'hFF);
    // all pins start as inputs, so software sets every direction bit first
    xfer(1, pog_pkg::DIR_OFFSET, 8'hFF);
    xfer(0, pog_pkg::LATCH_OFFSET, 8'h00); chk(r, 32'h00000000);
    settle; chk(pin_out, 8'h5A);
    complete_run;
  end
endmodule
